// ==== design/vxi_regs_pkg.sv ====
// Overview of operation
// - identification read-only to host, processor writes early
// - device type read-only to host, loaded early
// - status reads slot/ready/pass/test; write inhibit, reset
// - window offset host read/write, processor read-only
// - wide access bit host read/write, module id bit follows slot line
// - four-bit self-test code, upper codes reserved
// - ready reads 1 when ready; pass after test
// - reset bit held 100 us then cleared
// - protocol register read-only to both sides
// - protocol bits default servant-only, interrupter present
// - response read-only to host, processor writes
// - response flag layout bits 13 to 7
// - read-ready cleared when host reads data word
// - write-ready cleared when host writes data word
// - host data write raises management interrupt
// - data word both ways, flags report occupancy
// - write only on write-ready, read on read-ready
// - processor port eight bits, low byte first
// - window decode uses offset as upper 16 bits
// - host uses sixteen-bit A16 transfers only
package vxi_regs_pkg;

  localparam int ADDR_W = 6;

  // register offsets in the A16 window
  localparam logic [5:0] OFF_IDENT    = 6'h00;
  localparam logic [5:0] OFF_DEVTYPE  = 6'h02;
  localparam logic [5:0] OFF_STATCTL  = 6'h04;
  localparam logic [5:0] OFF_WINBASE  = 6'h06;
  localparam logic [5:0] OFF_PROTOCOL = 6'h08;
  localparam logic [5:0] OFF_RESPONSE = 6'h0a;
  localparam logic [5:0] OFF_DATAWORD = 6'h0e;

  // status/control field positions
  localparam int SC_WIDE_SPACE = 15;
  localparam int SC_MODULE_ID  = 14;
  localparam int SC_TEST_LSB   = 4;
  localparam int SC_READY      = 3;
  localparam int SC_PASS       = 2;
  localparam int SC_SYSFAIL_INH = 1;
  localparam int SC_CARRIER_RST = 0;
  localparam logic [15:0] SC_RESET     = 16'h0000;
  localparam logic [15:0] SC_CPU_MASK  = 16'h00fc;
  localparam logic [15:0] SC_HOST_MASK = 16'h8003;
  localparam logic [15:0] SC_READ_MASK = 16'h80ff;

  // self-test codes
  localparam logic [3:0] TEST_PASSED   = 4'h0;
  localparam logic [3:0] TEST_SDRAM    = 4'h1;
  localparam logic [3:0] TEST_SHARED   = 4'h2;
  localparam logic [3:0] TEST_FLASH    = 4'h3;
  localparam logic [3:0] TEST_REGISTER = 4'h4;

  // protocol: servant-only, no notify reg, no master, interrupter,
  // no quick handshake, no shared memory protocol
  localparam logic [15:0] PROTOCOL_VALUE = 16'hfc00;

  // response field positions
  localparam int RSP_OUT_READY = 13;
  localparam int RSP_IN_READY  = 12;
  localparam int RSP_ERROR_N   = 11;
  localparam int RSP_READ_OK   = 10;
  localparam int RSP_WRITE_OK  = 9;
  localparam int RSP_QUICK_N   = 8;
  localparam int RSP_LOCK_N    = 7;
  localparam logic [15:0] RSP_RESET    = 16'h0b80;
  localparam logic [15:0] RSP_CPU_MASK = 16'h3f80;

  // host controller APB map
  localparam logic [7:0] APB_CTRL   = 8'h00;
  localparam logic [7:0] APB_WDATA  = 8'h04;
  localparam logic [7:0] APB_RDATA  = 8'h08;
  localparam logic [7:0] APB_STATUS = 8'h0c;
  localparam int CTRL_CMD_LSB = 8;
  localparam int CTRL_SLOT    = 12;

  // host controller orders
  localparam logic [2:0] CMD_NONE   = 3'h0;
  localparam logic [2:0] CMD_READ   = 3'h1;
  localparam logic [2:0] CMD_WRITE  = 3'h2;
  localparam logic [2:0] CMD_SEND   = 3'h3;
  localparam logic [2:0] CMD_RECV   = 3'h4;
  localparam logic [2:0] CMD_CRESET = 3'h5;

  // carrier reset hold time
  localparam int PCLK_PERIOD_PS     = 5000;
  localparam int CRESET_HOLD_US     = 100;
  localparam int CRESET_HOLD_CYCLES =
    (CRESET_HOLD_US * 1000000 + PCLK_PERIOD_PS - 1) / PCLK_PERIOD_PS;

  typedef enum logic [2:0] {
    ST_IDLE, ST_POLL, ST_XFER, ST_HOLD, ST_RELEASE
  } host_state_t;

endpackage : vxi_regs_pkg

// ==== design/vxi_link_if.sv ====
interface vxi_link_if;
  logic        req;
  logic        we;
  logic [5:0]  addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        ack;
  logic        modid_n;

  modport device (input req, we, addr, wdata, modid_n, output rdata, ack);
  modport host   (output req, we, addr, wdata, modid_n, input rdata, ack);
endinterface : vxi_link_if

// ==== design/vxi_config_message_registers.sv ====
// Implementation choice: register access over the req/ack link and an 8-bit processor port.
module vxi_config_message_registers #(
  parameter logic [15:0] IDENT_RESET   = 16'h5a5a, // arbitrary value
  parameter logic [15:0] DEVTYPE_RESET = 16'h1234  // arbitrary value
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  vxi_link_if.device       link,
  input  wire logic        cpu_sel,
  input  wire logic        cpu_we,
  input  wire logic [vxi_regs_pkg::ADDR_W-1:0] cpu_addr,
  input  wire logic [7:0]  cpu_wdata,
  output logic      [7:0]  cpu_rdata,
  input  wire logic        msg_irq_disable,
  input  wire logic [31:0] wide_addr,
  input  wire logic        wide_a32,
  output logic             window_hit,
  output logic             mgmt_irq,
  output logic             sysfail_inhibit,
  output logic             carrier_reset,
  output logic      [15:0] window_base
);
  import vxi_regs_pkg::*;

  logic        ack_reg;
  logic [15:0] rdata_reg;
  logic [7:0]  cpu_rdata_reg;
  logic [15:0] ident_reg;
  logic [15:0] devtype_reg;
  logic        cfg_locked_reg;
  logic [15:0] statctl_reg;
  logic [15:0] winbase_reg;
  logic [15:0] response_reg;
  logic [15:0] dataword_reg;
  logic        mgmt_irq_reg;
  logic        window_hit_reg;
  logic        modid_s1_reg;
  logic        modid_s2_reg;
  logic        modid_s3_reg;
  logic        module_id_reg;

  logic        host_acc;
  logic        host_wr;
  logic        host_rd;
  logic        cpu_wr;
  logic [5:0]  cpu_word_addr;
  logic [15:0] cpu_word;
  logic [15:0] cpu_view;

  // one access per request; ack gates the second cycle of the same request
  assign host_acc      = link.req & ~ack_reg;
  assign host_wr       = host_acc & link.we;
  assign host_rd       = host_acc & ~link.we;
  assign cpu_wr        = cpu_sel & cpu_we;
  assign cpu_word_addr = {cpu_addr[5:1], 1'b0};

  // read view of a 16-bit register, reserved offsets give zero
  function automatic logic [15:0] read_word(input logic [5:0] a);
    case (a)
      OFF_IDENT:    read_word = ident_reg;
      OFF_DEVTYPE:  read_word = devtype_reg;
      OFF_STATCTL:  read_word = (statctl_reg & SC_READ_MASK)
                                | {1'b0, module_id_reg, 14'h0000};
      OFF_WINBASE:  read_word = winbase_reg;
      OFF_PROTOCOL: read_word = PROTOCOL_VALUE;
      OFF_RESPONSE: read_word = response_reg & RSP_CPU_MASK;
      OFF_DATAWORD: read_word = dataword_reg;
      default:      read_word = 16'h0000;
    endcase
  endfunction

  // byte write from the processor merged into the current word
  always_comb begin
    cpu_view = read_word(cpu_word_addr);
    cpu_word = cpu_view;
    if (cpu_addr[0]) begin
      cpu_word[15:8] = cpu_wdata;
    end else begin
      cpu_word[7:0] = cpu_wdata;
    end
  end

  // keep only the bits a side owns, the rest hold their value
  function automatic logic [15:0] merge(input logic [15:0] cur,
                                        input logic [15:0] nw,
                                        input logic [15:0] mask);
    merge = (cur & ~mask) | (nw & mask);
  endfunction

  // link answer: one cycle after the request is seen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 16'h0000;
    end else begin
      ack_reg <= host_acc;
      if (host_rd) begin
        rdata_reg <= read_word({link.addr[5:1], 1'b0});
      end
    end
  end

  // processor read data, valid the cycle after the strobe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_rdata_reg <= 8'h00;
    end else if (cpu_sel && !cpu_we) begin
      cpu_rdata_reg <= cpu_addr[0] ? cpu_view[15:8] : cpu_view[7:0];
    end
  end

  // slot line: three stages, accepted when the last two agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      modid_s1_reg  <= 1'b1;
      modid_s2_reg  <= 1'b1;
      modid_s3_reg  <= 1'b1;
      module_id_reg <= 1'b1;
    end else begin
      modid_s1_reg <= link.modid_n;
      modid_s2_reg <= modid_s1_reg;
      modid_s3_reg <= modid_s2_reg;
      if (modid_s2_reg == modid_s3_reg) begin
        module_id_reg <= modid_s3_reg;
      end
    end
  end

  // identity words: first host access marks resource management begun
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ident_reg      <= IDENT_RESET;
      devtype_reg    <= DEVTYPE_RESET;
      cfg_locked_reg <= 1'b0;
    end else begin
      if (host_acc) begin
        cfg_locked_reg <= 1'b1;
      end
      if (cpu_wr && !cfg_locked_reg && cpu_word_addr == OFF_IDENT) begin
        ident_reg <= cpu_word;
      end
      if (cpu_wr && !cfg_locked_reg && cpu_word_addr == OFF_DEVTYPE) begin
        devtype_reg <= cpu_word;
      end
    end
  end

  // status/control: processor owns test result, host owns controls
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      statctl_reg <= SC_RESET;
    end else if (host_wr && link.addr == OFF_STATCTL) begin
      statctl_reg <= merge(statctl_reg, link.wdata, SC_HOST_MASK);
    end else if (cpu_wr && cpu_word_addr == OFF_STATCTL) begin
      statctl_reg <= merge(statctl_reg, cpu_word, SC_CPU_MASK);
    end
  end

  // window base is host-written only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      winbase_reg <= 16'h0000;
    end else if (host_wr && link.addr == OFF_WINBASE) begin
      winbase_reg <= link.wdata;
    end
  end

  // response flags; a processor set beats a hardware clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      response_reg <= RSP_RESET;
    end else if (cpu_wr && cpu_word_addr == OFF_RESPONSE) begin
      response_reg <= merge(response_reg, cpu_word, RSP_CPU_MASK);
    end else begin
      if (host_rd && link.addr == OFF_DATAWORD) begin
        response_reg[RSP_READ_OK] <= 1'b0;
      end
      if (host_wr && link.addr == OFF_DATAWORD) begin
        response_reg[RSP_WRITE_OK] <= 1'b0;
      end
    end
  end

  // data word: the host wins a same-cycle collision
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dataword_reg <= 16'h0000;
    end else if (host_wr && link.addr == OFF_DATAWORD) begin
      dataword_reg <= link.wdata;
    end else if (cpu_wr && cpu_word_addr == OFF_DATAWORD) begin
      dataword_reg <= cpu_word;
    end
  end

  // one-cycle interrupt per host data write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mgmt_irq_reg <= 1'b0;
    end else begin
      mgmt_irq_reg <= host_wr && link.addr == OFF_DATAWORD
                      && !msg_irq_disable;
    end
  end

  // wide window compare; a24 uses bits 23:8, a32 bits 31:16
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      window_hit_reg <= 1'b0;
    end else begin
      window_hit_reg <= statctl_reg[SC_WIDE_SPACE]
                        && (wide_a32 ? wide_addr[31:16] == winbase_reg
                                     : wide_addr[23:8] == winbase_reg);
    end
  end

  assign link.ack        = ack_reg;
  assign link.rdata      = rdata_reg;
  assign cpu_rdata       = cpu_rdata_reg;
  assign window_hit      = window_hit_reg;
  assign mgmt_irq        = mgmt_irq_reg;
  assign sysfail_inhibit = statctl_reg[SC_SYSFAIL_INH];
  assign carrier_reset   = statctl_reg[SC_CARRIER_RST];
  assign window_base     = winbase_reg;

endmodule // vxi_config_message_registers

// ==== design/vxi_host_controller.sv ====
module vxi_host_controller #(
  parameter int HOLD_CYCLES = vxi_regs_pkg::CRESET_HOLD_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  vxi_link_if.host         link
);
  import vxi_regs_pkg::*;

  host_state_t state_reg;
  logic [2:0]  cmd_reg;
  logic [5:0]  addr_reg;
  logic        slot_reg;
  logic [15:0] wdata_reg;
  logic [15:0] rdata_reg;
  logic        req_reg;
  logic        we_reg;
  logic [5:0]  laddr_reg;
  logic [15:0] lwdata_reg;
  logic [31:0] hold_cnt_reg;
  logic [31:0] prdata_reg;
  logic        pready_reg;
  logic        pslverr_reg;
  logic        apb_wr;
  logic        mapped;
  logic        start;
  logic [31:0] read_mux;

  assign apb_wr = psel & penable & pwrite & pready_reg;
  assign mapped = paddr == APB_CTRL || paddr == APB_WDATA
                  || paddr == APB_RDATA || paddr == APB_STATUS;
  assign start  = apb_wr && paddr == APB_CTRL && state_reg == ST_IDLE
                  && pwdata[CTRL_CMD_LSB +: 3] != CMD_NONE;

  always_comb begin
    case (paddr)
      APB_CTRL:   read_mux = {19'h0, slot_reg, 1'b0, cmd_reg, 2'b00, addr_reg};
      APB_WDATA:  read_mux = {16'h0000, wdata_reg};
      APB_RDATA:  read_mux = {16'h0000, rdata_reg};
      APB_STATUS: read_mux = {31'h0, state_reg != ST_IDLE};
      default:    read_mux = 32'h0000_0000;
    endcase
  end

  // apb answer: one wait state, data and error set with pready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= psel & penable & ~pready_reg;
      pslverr_reg <= psel & penable & ~pready_reg & ~mapped;
      if (psel && penable && !pready_reg) begin
        prdata_reg <= pwrite ? 32'h0000_0000 : read_mux;
      end
    end
  end

  // order registers; ctrl is refused while a job runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_reg   <= CMD_NONE;
      addr_reg  <= 6'h00;
      slot_reg  <= 1'b0;
      wdata_reg <= 16'h0000;
    end else begin
      if (start) begin
        cmd_reg  <= pwdata[CTRL_CMD_LSB +: 3];
        addr_reg <= {pwdata[5:1], 1'b0};
        slot_reg <= pwdata[CTRL_SLOT];
      end
      if (apb_wr && paddr == APB_WDATA) begin
        wdata_reg <= pwdata[15:0];
      end
    end
  end

  // job sequencer driving the 16-bit link; req drops on the ack edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg    <= ST_IDLE;
      req_reg      <= 1'b0;
      we_reg       <= 1'b0;
      laddr_reg    <= 6'h00;
      lwdata_reg   <= 16'h0000;
      rdata_reg    <= 16'h0000;
      hold_cnt_reg <= 32'h0000_0000;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (start) begin
            state_reg <= (pwdata[CTRL_CMD_LSB +: 3] == CMD_SEND
                          || pwdata[CTRL_CMD_LSB +: 3] == CMD_RECV) ? ST_POLL : ST_XFER;
          end
        end
        ST_POLL: begin
          // handshake order: transfer only once the flag is up
          if (!req_reg) begin
            req_reg   <= 1'b1;
            we_reg    <= 1'b0;
            laddr_reg <= OFF_RESPONSE;
          end else if (link.ack) begin
            req_reg <= 1'b0;
            if (cmd_reg == CMD_SEND ? link.rdata[RSP_WRITE_OK]
                                    : link.rdata[RSP_READ_OK]) begin
              state_reg <= ST_XFER;
            end
          end
        end
        ST_XFER: begin
          if (!req_reg) begin
            req_reg    <= 1'b1;
            we_reg     <= cmd_reg == CMD_WRITE || cmd_reg == CMD_SEND
                          || cmd_reg == CMD_CRESET;
            laddr_reg  <= cmd_reg == CMD_SEND || cmd_reg == CMD_RECV ? OFF_DATAWORD
                        : cmd_reg == CMD_CRESET ? OFF_STATCTL : addr_reg;
            lwdata_reg <= cmd_reg == CMD_CRESET ? (wdata_reg | 16'h0001) : wdata_reg;
          end else if (link.ack) begin
            req_reg <= 1'b0;
            if (!we_reg) begin
              rdata_reg <= link.rdata;
            end
            hold_cnt_reg <= 32'h0000_0000;
            state_reg    <= cmd_reg == CMD_CRESET ? ST_HOLD : ST_IDLE;
          end
        end
        ST_HOLD: begin
          // keep the carrier in reset for the full minimum time
          hold_cnt_reg <= hold_cnt_reg + 32'h0000_0001;
          if (hold_cnt_reg >= 32'(HOLD_CYCLES - 1)) begin
            state_reg <= ST_RELEASE;
          end
        end
        ST_RELEASE: begin
          if (!req_reg) begin
            req_reg    <= 1'b1;
            we_reg     <= 1'b1;
            laddr_reg  <= OFF_STATCTL;
            lwdata_reg <= wdata_reg & 16'hfffe;
          end else if (link.ack) begin
            req_reg   <= 1'b0;
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
          req_reg   <= 1'b0;
        end
      endcase
    end
  end

  // slot select line asserted low from the ctrl bit
  logic modid_n_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      modid_n_reg <= 1'b1;
    end else begin
      modid_n_reg <= ~slot_reg;
    end
  end

  assign prdata        = prdata_reg;
  assign pready        = pready_reg;
  assign pslverr       = pslverr_reg;
  assign link.req      = req_reg;
  assign link.we       = we_reg;
  assign link.addr     = laddr_reg;
  assign link.wdata    = lwdata_reg;
  assign link.modid_n  = modid_n_reg;

endmodule // vxi_host_controller

// ==== tb/vxi_link_properties.sv ====
module vxi_link_properties (
  input logic        pclk,
  input logic        presetn,
  input logic        req,
  input logic        we,
  input logic [5:0]  addr,
  input logic [15:0] wdata,
  input logic [15:0] rdata,
  input logic        ack,
  input logic        modid_n
);
  timeunit 1ns;
  timeprecision 100ps;
  import vxi_regs_pkg::*;

  // single domain, so one clock and one reset for every property
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // the device answers a taken request exactly one cycle later
  ack_answer_a: assert property (req && !ack |=> ack)
    else $error("link request not answered after one cycle");
  // the host holds the whole request until the answer
  req_hold_a: assert property (req && !ack |=> req && $stable({we, addr, wdata}))
    else $error("link request changed before its answer");
  // ack is a pulse and the host lets go on it
  ack_pulse_a: assert property (ack |=> !ack && !req)
    else $error("link ack or request stayed up");
  ack_cause_a: assert property (ack |-> req && $past(req))
    else $error("link ack without a request");
  // only whole 16-bit words travel over the link
  addr_even_a: assert property (req |-> !addr[0])
    else $error("odd link address");
  proto_read_a: assert property (ack && !we && addr == OFF_PROTOCOL
                                 |-> rdata == 16'hfc00)
    else $error("protocol word wrong");
  rsvd_read_a: assert property (ack && !we && (addr == 6'h0c || addr >= 6'h10)
                                |-> rdata == 16'h0000)
    else $error("reserved offset read not zero");
  rsp_layout_a: assert property (ack && !we && addr == OFF_RESPONSE
                                 |-> (rdata & ~RSP_CPU_MASK) == 16'h0000)
    else $error("response reserved bits not zero");
  // slot select is synchronised, so it must have settled for a while
  modid_high_a: assert property (modid_n [*8] ##0 (ack && !we && addr == OFF_STATCTL)
                                 |-> rdata[SC_MODULE_ID])
    else $error("module id bit low while slot not selected");
  modid_low_a: assert property (!modid_n [*8] ##0 (ack && !we && addr == OFF_STATCTL)
                                |-> !rdata[SC_MODULE_ID])
    else $error("module id bit high while slot selected");

  cover property (ack && we && addr == OFF_DATAWORD);
  cover property (ack && !we && addr == OFF_DATAWORD);
  cover property (ack && we && addr == OFF_STATCTL);
endmodule // vxi_link_properties

// ==== tb/tb_top.sv ====
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import vxi_regs_pkg::*;

  localparam int HOLD = 20; // shortened carrier reset hold

  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        cpu_sel = 1'b0, cpu_we = 1'b0, msg_irq_disable = 1'b0, wide_a32 = 1'b0;
  logic        slot = 1'b1;
  logic        pready, pslverr, window_hit, mgmt_irq, sysfail_inhibit, carrier_reset, err;
  logic [7:0]  paddr = 8'h00, cpu_wdata = 8'h00;
  logic [5:0]  cpu_addr = 6'h00;
  logic [31:0] pwdata = 32'h0, wide_addr = 32'h0;
  logic [7:0]  cpu_rdata, byte_v;
  logic [15:0] window_base, hv;
  logic [31:0] prdata, rv;
  int          error_cnt, tests_run, irq_cnt, rst_cyc, n0;

  always #2.5 pclk = ~pclk;

  // count interrupt pulses and cycles spent in carrier reset
  always @(posedge pclk) begin
    if (mgmt_irq === 1'b1) irq_cnt <= irq_cnt + 1;
    if (carrier_reset === 1'b1) rst_cyc <= rst_cyc + 1;
  end

  vxi_link_if link ();

  vxi_config_message_registers #(.IDENT_RESET(16'h2c71), .DEVTYPE_RESET(16'h0b0e))
    vxi_config_message_registers_i (.pclk(pclk), .presetn(presetn), .link(link),
    .cpu_sel(cpu_sel), .cpu_we(cpu_we), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
    .cpu_rdata(cpu_rdata), .msg_irq_disable(msg_irq_disable), .wide_addr(wide_addr),
    .wide_a32(wide_a32), .window_hit(window_hit), .mgmt_irq(mgmt_irq),
    .sysfail_inhibit(sysfail_inhibit), .carrier_reset(carrier_reset),
    .window_base(window_base));

  vxi_host_controller #(.HOLD_CYCLES(HOLD)) vxi_host_controller_i (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));

  vxi_link_properties vxi_link_properties_i (.pclk(pclk), .presetn(presetn),
    .req(link.req), .we(link.we), .addr(link.addr), .wdata(link.wdata),
    .rdata(link.rdata), .ack(link.ack), .modid_n(link.modid_n));

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one APB transfer; result lands in rv and err
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // the transfer ends at the first rising edge that samples pready high
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rv      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // one link order, polled to completion; read result lands in hv
  task automatic lop(input logic [2:0] c, input logic [5:0] a, input logic [15:0] d);
    apb(1'b1, APB_WDATA, {16'h0000, d});
    apb(1'b1, APB_CTRL, {19'h00000, slot, 1'b0, c, 2'b00, a});
    do apb(1'b0, APB_STATUS, 32'h0); while (rv[0] !== 1'b0);
    apb(1'b0, APB_RDATA, 32'h0);
    hv = rv[15:0];
  endtask

  // one processor byte access; read data lands in byte_v
  task automatic cpu(input logic w, input logic [5:0] a, input logic [7:0] d);
    @(posedge pclk);
    cpu_sel   <= 1'b1;
    cpu_we    <= w;
    cpu_addr  <= a;
    cpu_wdata <= d;
    @(posedge pclk);
    cpu_sel <= 1'b0;
    #1;
    byte_v = cpu_rdata;
  endtask

  // decode is registered, so give it a few cycles
  task automatic win(input logic a32, input logic [31:0] a, input logic e);
    @(posedge pclk);
    wide_a32  <= a32;
    wide_addr <= a;
    repeat (3) @(posedge pclk);
    #1;
    chk("window_hit", {15'h0, e}, {15'h0, window_hit});
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    // identification is open to the processor only until the host shows up
    cpu(1'b0, 6'h00, 8'h00);
    chk("ident_lo", 16'h0071, {8'h0, byte_v});
    cpu(1'b1, 6'h00, 8'ha5);
    cpu(1'b1, 6'h01, 8'h3c);
    lop(CMD_READ, OFF_IDENT, 16'h0);
    chk("ident", 16'h3ca5, hv);
    lop(CMD_WRITE, OFF_IDENT, 16'hffff);
    cpu(1'b1, 6'h00, 8'h00);
    lop(CMD_READ, OFF_IDENT, 16'h0);
    chk("ident_locked", 16'h3ca5, hv);
    lop(CMD_READ, OFF_DEVTYPE, 16'h0);
    chk("devtype", 16'h0b0e, hv);
    lop(CMD_WRITE, OFF_PROTOCOL, 16'h0000);
    lop(CMD_READ, OFF_PROTOCOL, 16'h0);
    chk("protocol", 16'hfc00, hv);
    cpu(1'b1, 6'h09, 8'h00);
    cpu(1'b0, 6'h09, 8'h00);
    chk("protocol_hi", 16'h00fc, {8'h0, byte_v});
    // host owns wide enable, inhibit and reset; processor owns test code, ready and pass only
    lop(CMD_WRITE, OFF_STATCTL, 16'hffff);
    lop(CMD_READ, OFF_STATCTL, 16'h0);
    chk("status", 16'h8003, hv);
    chk("sysfail", 16'h0001, {15'h0, sysfail_inhibit});
    chk("creset", 16'h0001, {15'h0, carrier_reset});
    lop(CMD_WRITE, OFF_STATCTL, 16'h0000);
    cpu(1'b1, 6'h05, 8'hff);
    for (int i = 0; i < 5; i++) begin
      cpu(1'b1, 6'h04, {i[3:0], 4'hc});
      lop(CMD_READ, OFF_STATCTL, 16'h0);
      chk("self_test", {8'h00, i[3:0], 4'hc}, hv);
    end
    slot = 1'b0;
    lop(CMD_READ, OFF_STATCTL, 16'h0);
    lop(CMD_READ, OFF_STATCTL, 16'h0);
    chk("module_id", 16'h404c, hv);
    slot = 1'b1;
    // window base: host writes, processor only reads
    lop(CMD_WRITE, OFF_WINBASE, 16'h1234);
    cpu(1'b1, 6'h06, 8'h00);
    cpu(1'b0, 6'h06, 8'h00);
    chk("base_lo", 16'h0034, {8'h0, byte_v});
    chk("window_base", 16'h1234, window_base);
    lop(CMD_WRITE, OFF_STATCTL, 16'h8000);
    win(1'b1, 32'h1234_0000, 1'b1);
    win(1'b0, 32'h0012_3400, 1'b1);
    win(1'b1, 32'h1235_0000, 1'b0);
    lop(CMD_WRITE, OFF_STATCTL, 16'h0000);
    win(1'b1, 32'h1234_0000, 1'b0);
    // word-serial exchange in both directions
    lop(CMD_WRITE, OFF_RESPONSE, 16'hffff);
    lop(CMD_READ, OFF_RESPONSE, 16'h0);
    chk("response", 16'h0b80, hv);
    lop(CMD_SEND, 6'h00, 16'h4d21);
    chk("irq_count", 16'h0001, irq_cnt[15:0]);
    lop(CMD_READ, OFF_RESPONSE, 16'h0);
    chk("write_ok", 16'h0980, hv);
    cpu(1'b0, 6'h0e, 8'h00);
    chk("data_lo", 16'h0021, {8'h0, byte_v});
    cpu(1'b0, 6'h0f, 8'h00);
    chk("data_hi", 16'h004d, {8'h0, byte_v});
    cpu(1'b1, 6'h0e, 8'h99);
    cpu(1'b1, 6'h0f, 8'h77);
    cpu(1'b1, 6'h0a, 8'h80);
    cpu(1'b1, 6'h0b, 8'h0f);
    lop(CMD_RECV, 6'h00, 16'h0);
    chk("recv", 16'h7799, hv);
    lop(CMD_READ, OFF_RESPONSE, 16'h0);
    chk("read_ok", 16'h0b80, hv);
    msg_irq_disable <= 1'b1;
    lop(CMD_SEND, 6'h00, 16'h0001);
    chk("irq_masked", 16'h0001, irq_cnt[15:0]);
    msg_irq_disable <= 1'b0;
    // carrier reset must stand for the whole hold
    #1;
    n0 = rst_cyc;
    lop(CMD_CRESET, 6'h00, 16'h0000);
    chk("hold", 16'h0001, {15'h0, rst_cyc - n0 >= HOLD && rst_cyc - n0 < HOLD + 8});
    chk("creset_off", 16'h0000, {15'h0, carrier_reset});
    // reserved offsets
    lop(CMD_WRITE, 6'h0c, 16'hffff);
    lop(CMD_READ, 6'h0c, 16'h0);
    chk("rsvd_0c", 16'h0000, hv);
    lop(CMD_READ, 6'h10, 16'h0);
    chk("rsvd_10", 16'h0000, hv);
    cpu(1'b0, 6'h0c, 8'h00);
    chk("rsvd_cpu", 16'h0000, {8'h0, byte_v});
    // controller side: mapped offsets answer clean, unmapped ones flag an error
    chk("apb_err", 16'h0000, {15'h0, err});
    apb(1'b0, 8'h10, 32'h0);
    chk("apb_unmapped", 16'h0001, {15'h0, err});
    chk("apb_unmapped_data", 16'h0000, rv[15:0]);
    give_verdict();
  end

  // hang guard: the whole sequence needs far less than this
  initial begin
    #200000;
    error_cnt++;
    give_verdict();
  end
endmodule // tb_top
